/* File: gfat_sequencer.sv */
/*
  Gyro fine-align torque sequencer: decodes the computer's pulse trains
  into relay, coil-steering and current-switch drives.
  Assumes pulse inputs are asynchronous pins, each pulse >= 3 us wide.
*/
// Operation
// - While enable pulses present, energize relay and power analog parts.
// - Active select steers current through chosen gyro's plus or minus coil.
// - Reset pulses hold the current switch reset before enable.
// - Reset command cuts off torque current to the gyro.
// - Only one gyro is torqued at any moment.
// - Set pulses set, reset pulses reset the current switch flip-flop.
// - Gyro torquing happens only in fine align mode.
// - Switch stays set until a reset pulse arrives; code also clears it on loss of enable or fine align.
// - With no gyro torqued, current flows through the dummy load.
// - Plus select gives positive float rotation, minus gives negative.
`timescale 1ns/1ns
`include "gfat_regs.svh"

module gfat_sequencer
  import gfat_pkg::*;
#(
  parameter int FAST_TMO = `GFAT_FAST_TMO_CYC, // Enable/select dead time
  parameter int SLOW_TMO = `GFAT_SLOW_TMO_CYC  // Unused reserve for slow
)(
  input  wire logic              i_clk,        // 100 MHz clock
  input  wire logic              i_rst_n,      // Async reset, active low
  input  wire logic              i_fine_align, // Fine align mode selected
  input  wire logic              i_torque_en,  // Enable pulse train pin
  input  wire logic [5:0]        i_gyro_sel,   // Select pulse train pins
  input  wire logic              i_torque_set, // Set pulse train pin
  input  wire logic              i_torque_rst, // Reset pulse train pin
  output gfat_drive_t            o_drive,      // Drives to torque path
  output logic                   o_sel_error   // More than one select live
);

  // ========================================================================
  // Elaboration checks
  // ========================================================================
  // The dead-time counter is 16 bits and must hold at least two cycles
  if (FAST_TMO < 2 || FAST_TMO > 65535 || SLOW_TMO < 2)
  begin : g_bad_param
    $error("gfat_sequencer: timeout parameters out of range");
  end

  // ========================================================================
  // Pin synchronisers, two flops each, plus edge history
  // ========================================================================
  localparam int NIN = `GFAT_NUM_SEL + 3;
  logic [NIN-1:0] pin_raw;
  logic [NIN-1:0] sync1_reg;
  logic [NIN-1:0] sync2_reg;
  logic [NIN-1:0] hist_reg;
  logic [NIN-1:0] rise;

  assign pin_raw = {i_torque_rst, i_torque_set, i_torque_en, i_gyro_sel};
  assign rise    = sync2_reg & ~hist_reg;

  // Metastability guard; only sync2 feeds logic
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      hist_reg  <= '0;
    end
    else
    begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      hist_reg  <= sync2_reg;
    end
  end

  // ========================================================================
  // Train detectors for enable and the six selects
  // ========================================================================
  localparam int NTR = `GFAT_NUM_SEL + 1;
  wire [NTR-1:0]  train_live;

  // Each detector owns its own flops, so no variable has two writers
  genvar g;
  generate
    for (g = 0; g < NTR; g++)
    begin : g_train
      logic [15:0] tmo_reg;
      logic        on_reg;

      always_ff @(posedge i_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          tmo_reg <= 16'h0000;
          on_reg  <= 1'b0;
        end
        else if (rise[g])
        begin
          tmo_reg <= 16'(FAST_TMO);
          on_reg  <= 1'b1;
        end
        else if (tmo_reg != 16'h0000)
          tmo_reg <= tmo_reg - 16'h0001;
        else
          on_reg  <= 1'b0;
      end

      assign train_live[g] = on_reg;
    end
  endgenerate

  // ========================================================================
  // Decode of enable, select and current switch commands
  // ========================================================================
  function automatic logic one_hot6(input logic [5:0] v);
    return (v != 6'h00) && ((v & (v - 6'h01)) == 6'h00);
  endfunction

  wire        en_live  = train_live[`GFAT_NUM_SEL];
  wire [5:0]  sel_live = train_live[`GFAT_NUM_SEL-1:0];
  wire        sel_ok   = one_hot6(sel_live);
  wire        set_rise = rise[NIN-2];
  wire        rst_rise = rise[NIN-1];
  wire        armed    = en_live & i_fine_align;
  logic       sw_reg;

  // set and reset inputs; holds until reset
  // reset wins and disarm clears; reset cuts current
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      sw_reg <= 1'b0;
    else if (rst_rise || !armed)
      sw_reg <= 1'b0;
    else if (set_rise)
      sw_reg <= 1'b1;
  end

  // ========================================================================
  // Registered drives to the analog path
  // ========================================================================
  gfat_drive_t drv_next;
  always_comb
  begin
    // relay and power while enable train is live
    drv_next.relay_on   = en_live;
    // steer only a single valid select; coil by line
    drv_next.coil_sel   = (sw_reg && armed && sel_ok) ? sel_live : 6'h00;
    drv_next.current_on = sw_reg && armed && sel_ok;
    // dummy load whenever no coil is driven
    drv_next.dummy_load = !(sw_reg && armed && sel_ok);
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_drive     <= '{relay_on: 1'b0, current_on: 1'b0,
                       dummy_load: 1'b1, coil_sel: 6'h00};
      o_sel_error <= 1'b0;
    end
    else
    begin
      o_drive     <= drv_next;
      o_sel_error <= (sel_live != 6'h00) && !sel_ok;
    end
  end

  // ========================================================================
  // Assertions
  // ========================================================================
  property p_one_coil;
    @(posedge i_clk) disable iff (!i_rst_n)
      $countones(o_drive.coil_sel) <= 1;
  endproperty
  a_one_coil: assert property (p_one_coil)
    else $error("more than one coil driven");

  property p_dummy_excl;
    @(posedge i_clk) disable iff (!i_rst_n)
      o_drive.dummy_load == (o_drive.coil_sel == 6'h00);
  endproperty
  a_dummy_excl: assert property (p_dummy_excl)
    else $error("dummy load not exclusive with coil");

  property p_reset_cuts;
    @(posedge i_clk) disable iff (!i_rst_n)
      rst_rise |-> ##2 !o_drive.current_on;
  endproperty
  a_reset_cuts: assert property (p_reset_cuts)
    else $error("current not cut after reset pulse");

  property p_set_holds;
    @(posedge i_clk) disable iff (!i_rst_n)
      (sw_reg && !rst_rise && armed) |=> sw_reg;
  endproperty
  a_set_holds: assert property (p_set_holds)
    else $error("switch dropped without reset");

  property p_set_takes;
    @(posedge i_clk) disable iff (!i_rst_n)
      (set_rise && !rst_rise && armed) |=> sw_reg;
  endproperty
  a_set_takes: assert property (p_set_takes)
    else $error("set pulse did not set switch");

  property p_relay;
    @(posedge i_clk) disable iff (!i_rst_n)
      en_live |=> o_drive.relay_on;
  endproperty
  a_relay: assert property (p_relay)
    else $error("relay not energized with enable");

  property p_fine_only;
    @(posedge i_clk) disable iff (!i_rst_n)
      !i_fine_align |=> ##1 !o_drive.current_on;
  endproperty
  a_fine_only: assert property (p_fine_only)
    else $error("torque outside fine align");

  property p_coil_match;
    @(posedge i_clk) disable iff (!i_rst_n)
      o_drive.current_on |-> (o_drive.coil_sel == $past(sel_live));
  endproperty
  a_coil_match: assert property (p_coil_match)
    else $error("coil differs from select");

  property p_train_live;
    @(posedge i_clk) disable iff (!i_rst_n)
      rise[0] |=> train_live[0] [*2];
  endproperty
  a_train_live: assert property (p_train_live)
    else $error("train not held live after pulse");

endmodule // gfat_sequencer

/* File: gfat_regs.svh */
/*
  Timing constants for the gyro fine-align torque sequencer.
  Assumes a 100 MHz core clock; all counts derive from it.
*/
`ifndef GFAT_REGS_SVH
`define GFAT_REGS_SVH

// ==========================================================================
// Clock and command timing
// ==========================================================================
`define GFAT_CLK_MHZ         100
`define GFAT_FAST_RATE_PPS   102400
`define GFAT_SLOW_RATE_PPS   3200
// Nominal periods in clock cycles (whole cycles, rounded down)
`define GFAT_FAST_PER_CYC    ((`GFAT_CLK_MHZ * 1000000) / `GFAT_FAST_RATE_PPS)
`define GFAT_SLOW_PER_CYC    ((`GFAT_CLK_MHZ * 1000000) / `GFAT_SLOW_RATE_PPS)
// A train is dead after this many nominal periods without a pulse
`define GFAT_MISS_PERIODS    4
`define GFAT_FAST_TMO_CYC    (`GFAT_FAST_PER_CYC * `GFAT_MISS_PERIODS)
`define GFAT_SLOW_TMO_CYC    (`GFAT_SLOW_PER_CYC * `GFAT_MISS_PERIODS)
`define GFAT_NUM_SEL         6

`endif

/* File: gfat_pkg.sv */
/*
  Types for the gyro fine-align torque sequencer.
  Assumes gfat_regs.svh supplies the numeric constants.
*/
package gfat_pkg;
  // ========================================================================
  // Drive outputs towards the analog torque path
  // ========================================================================
  typedef struct packed {
    logic       relay_on;   // Enable relay, reference and amp powered
    logic       current_on; // Switch flip-flop set, current into coil
    logic       dummy_load; // Current diverted into the dummy load
    logic [5:0] coil_sel;   // One-hot coil switch, {Z-,Z+,Y-,Y+,X-,X+}
  } gfat_drive_t;
endpackage

/* File: gfat_computer_model.sv */
/*
  Guidance computer model: makes the nine command pulse trains.
  Assumes one clock shared with the sequencer; pins idle low.
*/
`timescale 1ns/1ns
module gfat_computer_model (
  input  wire logic       i_clk,    // Clock
  input  wire logic       i_rst_n,  // Reset, active low
  input  wire logic       i_en_on,  // Run enable train
  input  wire logic [5:0] i_sel_on, // Select trains to run
  input  wire logic       i_set_on, // Torquing wanted
  input  wire logic       i_rst_on, // Reset train allowed when idle
  output logic            o_en,     // Enable pin
  output logic [5:0]      o_sel,    // Select pins
  output logic            o_set,    // Set pin
  output logic            o_rst     // Reset pin
);
  // ==================================================================
  // Phase counter
  // ==================================================================
  logic [3:0] cnt_reg;
  logic       fast;
  logic       slow;

  // Free running; trains are scaled down so the run stays short
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
      cnt_reg <= 4'h0;
    else
      cnt_reg <= cnt_reg + 4'h1;

  // Three cycle pulses, period 8 fast and 16 slow
  assign fast = cnt_reg[2:0] < 3'h3;
  assign slow = cnt_reg < 4'h3;
  assign o_en  = i_en_on & fast;
  assign o_sel = i_sel_on & {6{fast}};
  assign o_set = i_set_on & slow;
  assign o_rst = !i_set_on & i_rst_on & slow;
endmodule // gfat_computer_model

/* File: tb.sv */
/*
  Testbench for the torque sequencer, driving it through the model.
  Assumes a 100 MHz clock and a shortened train dead time.
*/
`timescale 1ns/1ns
module tb;
  import gfat_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        fine = 1'b0;
  logic        en_on = 1'b0;
  logic        set_on = 1'b0;
  logic        rst_on = 1'b1;
  logic [5:0]  sel_on = 6'h00;
  logic        en_p;
  logic        set_p;
  logic        rst_p;
  logic [5:0]  sel_p;
  gfat_drive_t drive;
  logic        sel_err;
  int          err_count = 0;
  int          n_compared = 0;
  int          cyc = 0;

  gfat_computer_model MDL (.i_clk(clk), .i_rst_n(rst_n), .i_en_on(en_on),
    .i_sel_on(sel_on), .i_set_on(set_on), .i_rst_on(rst_on), .o_en(en_p),
    .o_sel(sel_p), .o_set(set_p), .o_rst(rst_p));
  // Dead time 20 keeps each train's 8 cycle spacing well inside it
  gfat_sequencer #(.FAST_TMO(20)) DUT (.i_clk(clk), .i_rst_n(rst_n),
    .i_fine_align(fine), .i_torque_en(en_p), .i_gyro_sel(sel_p),
    .i_torque_set(set_p), .i_torque_rst(rst_p), .o_drive(drive),
    .o_sel_error(sel_err));

  // ==================================================================
  // Clock, timeout and helpers
  // ==================================================================
  always #5 clk = ~clk;

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      err_count++;
      stop_test();
    end
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Read live on the falling edge, clear of the design's updates;
  // return on a rising edge so the next stimulus stays edge aligned
  task automatic chk_drv(input string nm, input logic [8:0] e);
    @(negedge clk);
    n_compared++;
    if (drive !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, drive);
      err_count++;
    end
    @(posedge clk);
  endtask

  task automatic chk_err(input string nm, input logic e);
    @(negedge clk);
    n_compared++;
    if (sel_err !== e)
    begin
      $display("[FAIL] %s expected %b seen %b", nm, e, sel_err);
      err_count++;
    end
    @(posedge clk);
  endtask

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==================================================================
  // Scenarios
  // ==================================================================
  task automatic t_idle();
    chk_drv("idle", {3'b001, 6'h00});
    chk_err("sel_err", 1'b0);
  endtask

  // Enable, select, set, reset, drop select for one coil
  task automatic t_gyro(input int k);
    @(posedge clk);
    en_on <= 1'b1;
    fine <= 1'b1;
    wt(20);
    sel_on <= 6'h01 << k;
    wt(16);
    set_on <= 1'b1;
    wt(24);
    chk_drv("torque", {3'b110, 6'h01 << k});
    set_on <= 1'b0;
    wt(24);
    chk_drv("cut", {3'b101, 6'h00});
    sel_on <= 6'h00;
    wt(30);
  endtask

  // Switch stays set with no reset pulses at all
  task automatic t_hold();
    sel_on <= 6'h04;
    wt(16);
    set_on <= 1'b1;
    wt(24);
    set_on <= 1'b0;
    rst_on <= 1'b0;
    wt(48);
    chk_drv("hold", {3'b110, 6'h04});
    rst_on <= 1'b1;
    wt(24);
    chk_drv("release", {3'b101, 6'h00});
  endtask

  // Set refused outside fine align or with two selects
  task automatic t_refuse(input logic f, input logic [5:0] s);
    fine <= f;
    sel_on <= s;
    wt(16);
    set_on <= 1'b1;
    wt(24);
    chk_drv("refuse", {3'b101, 6'h00});
    chk_err("multi", s == 6'h03);
    set_on <= 1'b0;
    sel_on <= 6'h00;
    fine <= 1'b1;
    wt(30);
  endtask

  // Losing the enable train drops relay and current
  task automatic t_loss();
    sel_on <= 6'h10;
    wt(16);
    set_on <= 1'b1;
    wt(24);
    chk_drv("pre_loss", {3'b110, 6'h10});
    en_on <= 1'b0;
    wt(40);
    chk_drv("loss", {3'b001, 6'h00});
    set_on <= 1'b0;
    sel_on <= 6'h00;
  endtask

  initial
  begin
    wt(2);
    rst_n <= 1'b1;
    t_idle();
    for (int k = 0; k < 6; k++)
      t_gyro(k);
    t_hold();
    t_refuse(1'b0, 6'h01);
    t_refuse(1'b1, 6'h03);
    t_loss();
    stop_test();
  end
endmodule // tb
